// File: hw/cpu_extract_pkg.sv
package cpu_extract_pkg;
	localparam int NUM_QUEUES = 8;
	localparam int NUM_CPU_PORTS = 2;
	localparam logic [3:0] CPU_PORT_LO = 4'hB;
	localparam logic [3:0] CPU_PORT_HI = 4'hC;
	localparam int HDR_BITS = 128;
	localparam int HDR_BYTES = 16;
	// Header field positions
	localparam int REWRITER_OP_CODE_POS = 118;
	localparam int RX_TIME_POS = 86;
	localparam int LAST_LEN_POS = 80;
	localparam int WORD_CNT_POS = 72;
	localparam int INGRESS_PORT_NUMBER_POS = 43;
	localparam int RULE_ID_POS = 37;
	localparam int SAMPLE_ID_POS = 32;
	localparam int RULE_HIT_POS = 31;
	localparam int DROP_PREC_POS = 30;
	localparam int LEARN_POS = 28;
	localparam int QMASK_POS = 20;
	localparam int QOS_POS = 17;
	localparam int TAG_KIND_POS = 16;
	localparam int PCP_POS = 13;
	localparam int DEI_POS = 12;
	localparam int VID_POS = 0;
	// Length encoding: bytes = WORD_BYTES*word_count + last_word_length - LEN_BIAS
	localparam int WORD_BYTES = 60;
	localparam int LEN_BIAS = 80;
	localparam logic [2:0] TWO_STEP_OP = 3'h3;
	// Register map (byte addresses)
	localparam logic [3:0] QMAP_OFS = 4'h0;
	localparam logic [3:0] PORT_CFG_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	localparam logic [7:0] QMAP_RST = 8'h00;
	localparam logic [3:0] PORT_CFG_RST = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA} egr_state_e;
endpackage : cpu_extract_pkg

// File: hw/cpu_frame_extraction.sv
// Functional notes
// - Each CPU-bound frame is stored in one of eight extraction queues.
// - Software map assigns each queue to CPU port 11 or 12.
// - Each CPU port has its own strict or round-robin scheduler over its queues.
// - Strict mode serves the highest-numbered non-empty mapped queue first.
// - Round robin serves mapped queues in turn, skipping none holding frames.
// - With header insertion enabled, each frame to that port gets the header.
// - Rewriter op is 9 bits at 118; op 3 carries timestamp id above.
// - Receive time sits in the 32-bit field at bit 86.
// - Length = 60*word_count + last_word_length - 80; fields at 72 and 80.
// - Ingress port number, 0 to 11, in 4 bits at bit 43.
// - Combined rule action id, 6 bits at 37, valid when rule hit set.
// - Sampling id at bit 32: 0-11 tx, 12 rx, 15 none.
// - Bit 31 set when a copy-to-host rule matched.
// - Bit 30 reports drop precedence after policing.
// - Learning action, 2 bits at 28: none, new, unlocked, locked.
// - Queue mask at bit 20, one bit per extraction queue hit.
// - Service class, 3 bits at bit 17.
// - Bit 16: 0 customer tag, 1 service or custom tag.
// - PCP at 13, DEI at 12, VID 12 bits at 0.
module cpu_frame_extraction
	import cpu_extract_pkg::*;
#(
	parameter int DATA_DEPTH = 256,
	parameter int DESC_DEPTH = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Frames from the switch core, metadata sampled with the first byte
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	input wire logic [8:0] in_rewriter_op_code,
	input wire logic [31:0] in_rx_time_value,
	input wire logic [3:0] in_ingress_port_number,
	input wire logic [5:0] in_rule_action_id,
	input wire logic [3:0] in_sampling_id,
	input wire logic in_rule_copy_hit,
	input wire logic in_drop_precedence,
	input wire logic [1:0] in_learning_action,
	input wire logic [7:0] in_extraction_queue_mask,
	input wire logic [2:0] in_service_class,
	input wire logic in_tag_kind,
	input wire logic [2:0] in_pcp,
	input wire logic in_dei,
	input wire logic [11:0] in_vid,
	// CPU ports: index 0 is port 11, index 1 is port 12
	output logic [1:0] out_valid,
	input wire logic [1:0] out_ready,
	output logic [15:0] out_data,
	output logic [1:0] out_last
);
	localparam int AW = $clog2(DATA_DEPTH);
	localparam int DW = $clog2(DESC_DEPTH);

	initial
	begin
		if (DATA_DEPTH < 4 || DESC_DEPTH < 2 || (DATA_DEPTH & (DATA_DEPTH - 1)) != 0
			|| (DESC_DEPTH & (DESC_DEPTH - 1)) != 0)
			$error("cpu_frame_extraction: depths must be powers of two, data >= 4");
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and AXI4-Lite slave
	logic [7:0] qmap_r;
	logic [1:0] rr_mode_r;
	logic [1:0] hdr_en_r;
	logic [3:0] aw_addr_r;
	logic aw_have_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_have_r;
	logic [7:0] q_busy;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 4'h0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			qmap_r <= QMAP_RST;
			rr_mode_r <= PORT_CFG_RST[1:0];
			hdr_en_r <= PORT_CFG_RST[3:2];
		end
		else
		begin
			// Registered readies: each reopens the cycle after the response is taken
			s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready)
				&& !(s_axi_bvalid && !s_axi_bready);
			s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready)
				&& !(s_axi_bvalid && !s_axi_bready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (aw_have_r && w_have_r)
			begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= RESP_OKAY;
				case (aw_addr_r)
					QMAP_OFS:
						if (w_strb_r[0])
							qmap_r <= w_data_r[7:0];
					PORT_CFG_OFS:
						if (w_strb_r[0])
						begin
							rr_mode_r <= w_data_r[1:0];
							hdr_en_r <= w_data_r[3:2];
						end
					STATUS_OFS:
						;
					default:
						s_axi_bresp <= RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Registered ready, low while a read answer is pending or being launched
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= !(s_axi_arvalid && s_axi_arready) && !(s_axi_rvalid && !s_axi_rready);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				QMAP_OFS:
					s_axi_rdata <= {24'h00_0000, qmap_r};
				PORT_CFG_OFS:
					s_axi_rdata <= {28'h000_0000, hdr_en_r, rr_mode_r};
				STATUS_OFS:
					s_axi_rdata <= {24'h00_0000, q_busy};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Queue storage
	logic [8:0] dmem [NUM_QUEUES][DATA_DEPTH];
	logic [HDR_BITS-1:0] hmem [NUM_QUEUES][DESC_DEPTH];
	logic [AW:0] dwp_r [NUM_QUEUES];
	logic [AW:0] drp_r [NUM_QUEUES];
	logic [DW-1:0] hwp_r [NUM_QUEUES];
	logic [DW-1:0] hrp_r [NUM_QUEUES];
	logic [DW:0] hcnt_r [NUM_QUEUES];
	logic [7:0] room_ok;

	genvar gq;
	generate
		for (gq = 0; gq < NUM_QUEUES; gq++)
		begin : g_q
			logic [AW:0] used;
			assign used = dwp_r[gq] - drp_r[gq];
			// Two bytes of slack because in_ready is registered
			assign room_ok[gq] = (used < (AW + 1)'(DATA_DEPTH - 2))
				&& (hcnt_r[gq] < (DW + 1)'(DESC_DEPTH));
			assign q_busy[gq] = (hcnt_r[gq] != '0);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Ingress: write bytes, commit descriptor at frame end
	logic in_frame_r;
	logic [2:0] tq_r;
	logic [15:0] len_r;
	logic [HDR_BITS-1:0] meta_r;
	logic [2:0] tq_nxt;
	logic [2:0] tq;
	logic in_take;
	logic commit;
	logic [15:0] flen;
	logic [15:0] biased;
	logic [HDR_BITS-1:0] meta_nxt;
	logic [HDR_BITS-1:0] hdr_nxt;

	assign in_take = in_valid && in_ready;
	assign tq = in_frame_r ? tq_r : tq_nxt;
	assign commit = in_take && in_last;
	assign flen = len_r + 16'h0001;
	assign biased = flen + 16'(LEN_BIAS);

	always_comb
	begin
		tq_nxt = 3'h0;
		for (int k = 0; k < NUM_QUEUES; k++)
			if (in_extraction_queue_mask[k])
				tq_nxt = 3'(k);
	end

	always_comb
	begin
		meta_nxt = '0;
		meta_nxt[REWRITER_OP_CODE_POS +: 9] = in_rewriter_op_code;
		meta_nxt[RX_TIME_POS +: 32] = in_rx_time_value;
		meta_nxt[INGRESS_PORT_NUMBER_POS +: 4] = in_ingress_port_number;
		meta_nxt[RULE_ID_POS +: 6] = in_rule_copy_hit ? in_rule_action_id : 6'h00;
		meta_nxt[SAMPLE_ID_POS +: 4] = in_sampling_id;
		meta_nxt[RULE_HIT_POS] = in_rule_copy_hit;
		meta_nxt[DROP_PREC_POS] = in_drop_precedence;
		meta_nxt[LEARN_POS +: 2] = in_learning_action;
		meta_nxt[QMASK_POS +: 8] = in_extraction_queue_mask;
		meta_nxt[QOS_POS +: 3] = in_service_class;
		meta_nxt[TAG_KIND_POS] = in_tag_kind;
		meta_nxt[PCP_POS +: 3] = in_pcp;
		meta_nxt[DEI_POS] = in_dei;
		meta_nxt[VID_POS +: 12] = in_vid;
		hdr_nxt = in_frame_r ? meta_r : meta_nxt;
		hdr_nxt[WORD_CNT_POS +: 8] = 8'(biased / 16'(WORD_BYTES));
		hdr_nxt[LAST_LEN_POS +: 6] = 6'(biased % 16'(WORD_BYTES));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			in_frame_r <= 1'b0;
			tq_r <= 3'h0;
			len_r <= 16'h0000;
			meta_r <= '0;
			in_ready <= 1'b0;
		end
		else
		begin
			if (in_take)
			begin
				in_frame_r <= !in_last;
				len_r <= in_last ? 16'h0000 : flen;
				if (!in_frame_r)
				begin
					tq_r <= tq_nxt;
					meta_r <= meta_nxt;
				end
			end
			// Bubble after a commit so a start sees the updated descriptor count;
			// mid-frame only the target queue matters, at a start every queue must have room
			in_ready <= commit ? 1'b0 : (in_frame_r || in_take) ? room_ok[tq] : &room_ok;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (in_take)
			dmem[tq][dwp_r[tq][AW-1:0]] <= {in_last, in_data};
		if (commit)
			hmem[tq][hwp_r[tq]] <= hdr_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Per-port schedulers and egress
	egr_state_e st_r [NUM_CPU_PORTS];
	logic [2:0] cq_r [NUM_CPU_PORTS];
	logic [2:0] last_q_r [NUM_CPU_PORTS];
	logic [HDR_BITS-1:0] sh_r [NUM_CPU_PORTS];
	logic [3:0] bcnt_r [NUM_CPU_PORTS];
	logic [1:0] adv;
	logic [1:0] start;
	logic [2:0] pq [NUM_CPU_PORTS];
	logic [1:0] dpop;

	function automatic logic [3:0] pick(input logic [7:0] av, input logic [2:0] last,
		input logic rr);
		logic [3:0] r;
		logic [2:0] i;
		r = 4'h0;
		if (rr)
		begin
			for (int k = NUM_QUEUES - 1; k >= 0; k--)
			begin
				i = last + 3'h1 + 3'(k);
				if (av[i])
					r = {1'b1, i};
			end
		end
		else
		begin
			for (int k = 0; k < NUM_QUEUES; k++)
				if (av[k])
					r = {1'b1, 3'(k)};
		end
		return r;
	endfunction : pick

	genvar gp;
	generate
		for (gp = 0; gp < NUM_CPU_PORTS; gp++)
		begin : g_p
			logic [7:0] mine;
			logic [3:0] sel;
			assign mine = (gp == 0) ? ~qmap_r : qmap_r;
			assign sel = pick(q_busy & mine, last_q_r[gp], rr_mode_r[gp]);
			assign adv[gp] = !out_valid[gp] || out_ready[gp];
			// Selection only in idle, so a queue is never switched mid-frame
			assign start[gp] = adv[gp] && (st_r[gp] == ST_IDLE) && sel[3];
			assign pq[gp] = sel[2:0];
			assign dpop[gp] = adv[gp] && (st_r[gp] == ST_DATA);

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					st_r[gp] <= ST_IDLE;
					cq_r[gp] <= 3'h0;
					last_q_r[gp] <= 3'h7;
					sh_r[gp] <= '0;
					bcnt_r[gp] <= 4'h0;
					out_valid[gp] <= 1'b0;
					out_data[gp*8 +: 8] <= 8'h00;
					out_last[gp] <= 1'b0;
				end
				else if (adv[gp])
				begin
					case (st_r[gp])
						ST_IDLE:
						begin
							out_valid[gp] <= 1'b0;
							out_last[gp] <= 1'b0;
							if (sel[3])
							begin
								cq_r[gp] <= pq[gp];
								last_q_r[gp] <= pq[gp];
								sh_r[gp] <= hmem[pq[gp]][hrp_r[pq[gp]]];
								bcnt_r[gp] <= 4'h0;
								st_r[gp] <= hdr_en_r[gp] ? ST_HDR : ST_DATA;
							end
						end
						ST_HDR:
						begin
							out_valid[gp] <= 1'b1;
							out_last[gp] <= 1'b0;
							out_data[gp*8 +: 8] <= sh_r[gp][HDR_BITS-1 -: 8];
							sh_r[gp] <= {sh_r[gp][HDR_BITS-9:0], 8'h00};
							bcnt_r[gp] <= bcnt_r[gp] + 4'h1;
							if (bcnt_r[gp] == 4'(HDR_BYTES - 1))
								st_r[gp] <= ST_DATA;
						end
						ST_DATA:
						begin
							out_valid[gp] <= 1'b1;
							{out_last[gp], out_data[gp*8 +: 8]} <=
								dmem[cq_r[gp]][drp_r[cq_r[gp]][AW-1:0]];
							if (dmem[cq_r[gp]][drp_r[cq_r[gp]][AW-1:0]][8])
								st_r[gp] <= ST_IDLE;
						end
						default:
							st_r[gp] <= ST_IDLE;
					endcase
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Queue pointers, shared by ingress and both ports
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int q = 0; q < NUM_QUEUES; q++)
			begin
				dwp_r[q] <= '0;
				drp_r[q] <= '0;
				hwp_r[q] <= '0;
				hrp_r[q] <= '0;
				hcnt_r[q] <= '0;
			end
		end
		else
		begin
			for (int q = 0; q < NUM_QUEUES; q++)
			begin
				logic inc;
				logic dec;
				inc = commit && (tq == 3'(q));
				dec = 1'b0;
				if (in_take && tq == 3'(q))
					dwp_r[q] <= dwp_r[q] + 1'b1;
				if (inc)
					hwp_r[q] <= hwp_r[q] + 1'b1;
				for (int p = 0; p < NUM_CPU_PORTS; p++)
				begin
					if (start[p] && pq[p] == 3'(q))
					begin
						dec = 1'b1;
						hrp_r[q] <= hrp_r[q] + 1'b1;
					end
					if (dpop[p] && cq_r[p] == 3'(q))
						drp_r[q] <= drp_r[q] + 1'b1;
				end
				hcnt_r[q] <= hcnt_r[q] + (DW + 1)'(inc) - (DW + 1)'(dec);
			end
		end
	end
endmodule : cpu_frame_extraction

// File: tb/fx_chk.sv
module fx_chk
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] out_valid,
	input wire logic [1:0] out_ready,
	input wire logic [15:0] out_data,
	input wire logic [1:0] out_last
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
	out0_hold_a: assert property (out_valid[0] && !out_ready[0]
		|=> out_valid[0] && $stable(out_data[7:0]) && $stable(out_last[0]))
		else $error("port 11 byte changed while stalled");
	out1_hold_a: assert property (out_valid[1] && !out_ready[1]
		|=> out_valid[1] && $stable(out_data[15:8]) && $stable(out_last[1]))
		else $error("port 12 byte changed while stalled");
	frame_gap0_a: assert property (&{out_valid[0], out_ready[0], out_last[0]}
		|=> !out_valid[0]) else $error("port 11 no gap");
	frame_gap1_a: assert property (&{out_valid[1], out_ready[1], out_last[1]}
		|=> !out_valid[1]) else $error("port 12 no gap");
	cover property (out_valid[0] && out_ready[0] && out_last[0]);
	cover property (out_valid[1] && out_ready[1] && out_last[1]);
	cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
	cover property (out_valid[0] && !out_ready[0]);
endmodule : fx_chk

// File: tb/cpu_reader.sv
module cpu_reader
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] hold,
	input wire logic slow,
	input wire logic [1:0] out_valid,
	input wire logic [15:0] out_data,
	input wire logic [1:0] out_last,
	output logic [1:0] out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got [2][$];
	int ends [2] = '{0, 0};
	logic [1:0] beat_r;
	// Slow mode takes a byte only every other cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			beat_r <= 2'h0;
			out_ready <= 2'h0;
		end
		else
		begin
			beat_r <= beat_r + 2'h1;
			out_ready <= ~hold & {2{!slow || beat_r[0]}};
		end
	end
	always @(posedge aclk)
		for (int p = 0; p < 2; p++)
			if (aresetn && out_valid[p] && out_ready[p])
			begin
				got[p].push_back(out_data[8*p+:8]);
				ends[p] += int'(out_last[p]);
			end
endmodule : cpu_reader

// File: tb/testbench.sv
module testbench
	import cpu_extract_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic in_valid = 1'b0, in_last = 1'b0, in_ready;
	logic [7:0] in_data = 8'h0;
	logic [127:0] m = '0;
	logic [1:0] hold = 2'h3, out_valid, out_ready, out_last;
	logic slow = 1'b0;
	logic [15:0] out_data;
	logic [7:0] xq [2][$];
	int error_cnt = 0;
	int n_tests = 0;
	always #5 aclk = ~aclk;
	cpu_frame_extraction #(.DATA_DEPTH(64), .DESC_DEPTH(4)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_last(in_last),
		.in_rewriter_op_code(m[126:118]), .in_rx_time_value(m[117:86]),
		.in_ingress_port_number(m[46:43]), .in_rule_action_id(m[42:37]),
		.in_sampling_id(m[35:32]), .in_rule_copy_hit(m[31]), .in_drop_precedence(m[30]),
		.in_learning_action(m[29:28]), .in_extraction_queue_mask(m[27:20]),
		.in_service_class(m[19:17]), .in_tag_kind(m[16]), .in_pcp(m[15:13]), .in_dei(m[12]),
		.in_vid(m[11:0]), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.out_last(out_last));
	cpu_reader rd_m (.aclk(aclk), .aresetn(aresetn), .hold(hold), .slow(slow),
		.out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [127:0] meta(input logic [7:0] k, input logic [7:0] msk);
		meta = '0;
		meta[126:118] = {k[5:0], TWO_STEP_OP};
		meta[117:86] = {24'h5A5A5A, k};
		meta[46:43] = 4'(k % 8'hC);
		meta[42:37] = 6'h2D;
		meta[35:28] = {k[3:0], k[3:0]};
		meta[27:20] = msk;
		meta[19:0] = {k[2:0], k[0], k[3:1], k[1], 4'hA, k};
	endfunction : meta
	task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v, input string what);
		n_tests++;
		if (got_v !== exp_v)
		begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, what, got_v, exp_v);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		// Late bready exercises the response hold
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
		chk(32'(bresp), 32'(r), "write resp");
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
		chk(rdata, d, "read data");
		chk(32'(rresp), 32'(r), "read resp");
	endtask : rd
	task automatic send(input logic [7:0] k, input logic [7:0] msk, input int n);
		for (int i = 0; i < n; i++)
		begin
			in_valid <= 1'b1;
			in_data <= k + 8'(i);
			in_last <= (i == n - 1);
			m <= meta(k, msk);
			do @(posedge aclk); while (!in_ready);
		end
	endtask : send
	task automatic want(input int p, input logic [7:0] k, input logic [7:0] msk, input int n,
		input bit h);
		logic [127:0] x;
		x = meta(k, msk);
		x[85:72] = {6'((n + 80) % 60), 8'((n + 80) / 60)};
		if (!x[31])
			x[42:37] = 6'h0;
		for (int i = 15; i >= 0 && h; i--)
			xq[p].push_back(x[8*i+:8]);
		for (int i = 0; i < n; i++)
			xq[p].push_back(k + 8'(i));
	endtask : want
	task automatic drain();
		int t;
		hold <= 2'h0;
		t = 0;
		while ((rd_m.got[0].size() < xq[0].size() || rd_m.got[1].size() < xq[1].size())
			&& t < 3000)
		begin
			@(posedge aclk);
			t++;
		end
		for (int p = 0; p < 2; p++)
		begin
			chk(32'(rd_m.got[p].size()), 32'(xq[p].size()), "byte count");
			while (xq[p].size() > 0 && rd_m.got[p].size() > 0)
				chk(32'(rd_m.got[p].pop_front()), 32'(xq[p].pop_front()), "stream byte");
			rd_m.got[p].delete();
			xq[p].delete();
		end
	endtask : drain
	task automatic results();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#200us;
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		results();
	end
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(QMAP_OFS, 32'h0, RESP_OKAY);
		rd(PORT_CFG_OFS, 32'h0, RESP_OKAY);
		rd(4'hC, 32'h0, RESP_SLVERR);
		wr(4'hC, 32'hFF, RESP_SLVERR);
		wr(QMAP_OFS, 32'hF0, RESP_OKAY);
		wr(PORT_CFG_OFS, 32'hE, RESP_OKAY);
		rd(QMAP_OFS, 32'hF0, RESP_OKAY);
		send(8'h23, 8'h0A, 40);
		send(8'h47, 8'h80, 4);
		send(8'h11, 8'h02, 3);
		send(8'h58, 8'h80, 2);
		send(8'h32, 8'h04, 5);
		send(8'h65, 8'h20, 3);
		in_valid <= 1'b0;
		// Queues 3 and 7 already handed their first frame to the idle ports
		rd(STATUS_OFS, 32'hA6, RESP_OKAY);
		want(0, 8'h23, 8'h0A, 40, 1'b1);
		want(0, 8'h32, 8'h04, 5, 1'b1);
		want(0, 8'h11, 8'h02, 3, 1'b1);
		want(1, 8'h47, 8'h80, 4, 1'b1);
		want(1, 8'h65, 8'h20, 3, 1'b1);
		want(1, 8'h58, 8'h80, 2, 1'b1);
		slow <= 1'b1;
		drain();
		wr(QMAP_OFS, 32'h01, RESP_OKAY);
		wr(PORT_CFG_OFS, 32'h8, RESP_OKAY);
		send(8'h70, 8'h01, 2);
		send(8'h84, 8'h40, 3);
		in_valid <= 1'b0;
		want(1, 8'h70, 8'h01, 2, 1'b1);
		want(0, 8'h84, 8'h40, 3, 1'b0);
		drain();
		chk(32'(rd_m.ends[0]), 32'h4, "port 11 frames");
		chk(32'(rd_m.ends[1]), 32'h4, "port 12 frames");
		results();
	end
endmodule : testbench

bind cpu_frame_extraction fx_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last));
